/* File: rtl/fae_addr_unit.sv */
/*
  Address formation for a serial NOR flash: bank register, extended
  address mode, space selection and sector split of each command.
  Assumes a command decoder in front that hands over one command per
  cmd_valid_i pulse with its address fully shifted in, and bank loads
  as separate pulses. All inputs are synchronous to sys_clk_i.
*/
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "fae_cfg.svh"

module fae_addr_unit (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  // Bank register load
  input  wire logic                 bank_wr_i,
  input  wire logic [7:0]           bank_data_i,
  // Command in
  input  wire logic                 cmd_valid_i,
  input  wire fae_pkg::fae_cmd_type cmd_i,
  // Address length the decoder must shift in
  output logic      [2:0]           addr_len_o,
  // Resolved command out
  output logic                      res_valid_o,
  output fae_pkg::fae_res_type      res_o,
  output logic                      array_wr_en_o,
  // Bank state
  output logic      [7:0]           bank_o,
  output logic                      ext_mode_o
);

  import fae_pkg::*;

  // --------------------------------------------------------------------
  // Bank register
  // --------------------------------------------------------------------
  logic [7:0] bank_q;
  logic       ext_mode;
  logic [6:0] bank_hi;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      bank_q <= `FAE_BANK_RST;
    else if (bank_wr_i)
      bank_q <= bank_data_i;
  end

  assign ext_mode   = bank_q[`FAE_BANK_EXT_BIT];
  assign bank_hi    = bank_q[`FAE_BANK_HI_MSB:0];
  assign bank_o     = bank_q;
  assign ext_mode_o = ext_mode;

  // --------------------------------------------------------------------
  // Command classification
  // --------------------------------------------------------------------
  logic          is_id;
  logic          full_addr;
  fae_space_type space;

  assign is_id = (cmd_i.opcode == `FAE_OPC_READ_ID);

  // Separate spaces and newer commands never use the bank
  assign full_addr = ext_mode
                   | cmd_i.four_byte
                   | cmd_i.alt_space
                   | is_id;

  always_comb
  begin
    if (is_id)
      space = FAE_SP_ID;
    else if (cmd_i.alt_space)
      space = FAE_SP_ALT;
    else
      space = FAE_SP_MAIN;
  end

  // Combinational so the decoder knows the length before the bytes come
  assign addr_len_o = full_addr ? `FAE_LEN_FULL
                                : `FAE_LEN_LEGACY;

  // --------------------------------------------------------------------
  // Effective address
  // --------------------------------------------------------------------
  logic [31:0] eff_addr;

  always_comb
  begin
    if (full_addr)
      eff_addr = cmd_i.addr;
    else
      // Received upper byte is ignored; with a zero bank only the
      // lowest 16 Mbytes are reachable
      eff_addr = {1'b0, bank_hi,
                  cmd_i.addr[`FAE_LEGACY_AW-1:0]};
  end

  logic [7:0]  sect;
  logic [18:0] offs;
  logic        in_arr;

  fae_sector_map #(
    .ADDR_W   (`FAE_FULL_AW),
    .SECT_LSB (`FAE_SECT_LSB),
    .SECT_W   (`FAE_SECT_W)
  ) u_sector_map (
    .addr_i     (eff_addr),
    .sector_o   (sect),
    .offset_o   (offs),
    .in_array_o (in_arr)
  );

  // --------------------------------------------------------------------
  // Result register
  // --------------------------------------------------------------------
  fae_res_type res_q;
  logic        res_valid_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      res_valid_q <= 1'b0;
    else
      res_valid_q <= cmd_valid_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      res_q <= '0;
    else if (cmd_valid_i)
    begin
      res_q.addr     <= eff_addr;
      res_q.space    <= space;
      res_q.sector   <= sect;
      res_q.offset   <= offs;
      res_q.in_array <= in_arr && (space == FAE_SP_MAIN);
      // Factory content: any write or erase aimed at it is dropped
      res_q.refused  <= is_id && cmd_i.write;
      res_q.write    <= cmd_i.write;
    end
  end

  assign res_valid_o   = res_valid_q;
  assign res_o         = res_q;
  // Only writes that are not refused reach the storage logic
  assign array_wr_en_o = res_valid_q && res_q.write
                       && !res_q.refused;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic legacy_cmd;
  assign legacy_cmd = cmd_valid_i && !cmd_i.four_byte
                    && !cmd_i.alt_space && !is_id;

  sequence s_take;
    cmd_valid_i;
  endsequence

  sequence s_answer;
    ##1 res_valid_o;
  endsequence

  property p_answer_next;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_take |-> s_answer;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("result did not follow a command by one cycle");

  property p_reset_bank;
    @(posedge sys_clk_i)
    sys_rst_i |=> (bank_o == 8'h00) && !ext_mode_o;
  endproperty
  a_reset_bank: assert property (p_reset_bank)
    else $error("bank or extended mode not cleared by reset");

  property p_bank_join;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    legacy_cmd && !ext_mode |=>
      res_o.addr == {1'b0, $past(bank_hi), $past(cmd_i.addr[23:0])};
  endproperty
  a_bank_join: assert property (p_bank_join)
    else $error("legacy address not joined with bank bits");

  property p_low_16m;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    legacy_cmd && (bank_q == 8'h00) |=> res_o.addr[31:24] == 8'h00;
  endproperty
  a_low_16m: assert property (p_low_16m)
    else $error("bare 24-bit address left the lowest 16 Mbytes");

  property p_len_legacy;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    legacy_cmd && !ext_mode |-> addr_len_o == 3'h3;
  endproperty
  a_len_legacy: assert property (p_len_legacy)
    else $error("legacy command not given three address bytes");

  property p_ext_full;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    legacy_cmd && ext_mode |->
      addr_len_o == 3'h4 ##1 res_o.addr == $past(cmd_i.addr);
  endproperty
  a_ext_full: assert property (p_ext_full)
    else $error("extended mode did not pass the full address");

  property p_new_full;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.four_byte |->
      addr_len_o == 3'h4 ##1 res_o.addr == $past(cmd_i.addr);
  endproperty
  a_new_full: assert property (p_new_full)
    else $error("newer command did not take the full address");

  property p_alt_full;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.alt_space && !is_id |=>
      res_o.space == FAE_SP_ALT && res_o.addr == $past(cmd_i.addr)
      && !res_o.in_array;
  endproperty
  a_alt_full: assert property (p_alt_full)
    else $error("separate space address not decoded at 32 bits");

  property p_id_space;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.opcode == 8'h9F |=>
      res_o.space == FAE_SP_ID && !res_o.in_array;
  endproperty
  a_id_space: assert property (p_id_space)
    else $error("identification read did not select its space");

  property p_id_locked;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && is_id && cmd_i.write |=>
      res_o.refused && !array_wr_en_o;
  endproperty
  a_id_locked: assert property (p_id_locked)
    else $error("write to identification space not refused");

  property p_sector_split;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    res_valid_o && res_o.in_array |->
      res_o.sector == res_o.addr[26:19] && res_o.addr[31:27] == 5'h00
      && res_o.offset == res_o.addr[18:0];
  endproperty
  a_sector_split: assert property (p_sector_split)
    else $error("sector index or offset wrong");

  property p_sector_range;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && space == FAE_SP_MAIN && eff_addr[31:27] == 5'h00
      |=> res_o.in_array;
  endproperty
  a_sector_range: assert property (p_sector_range)
    else $error("address inside 256 sectors flagged outside");

  property p_full_reach;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && full_addr |=> res_o.addr == $past(cmd_i.addr);
  endproperty
  a_full_reach: assert property (p_full_reach)
    else $error("full address altered");

  property p_bank_load;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    bank_wr_i |=> bank_o == $past(bank_data_i);
  endproperty
  a_bank_load: assert property (p_bank_load)
    else $error("bank register did not load");

  // Bank value stands between loads
  property p_bank_hold;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !bank_wr_i |=> $stable(bank_o);
  endproperty
  a_bank_hold: assert property (p_bank_hold)
    else $error("bank register changed without a load");

  // The result stands until the next command replaces it
  property p_res_hold;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !cmd_valid_i |=> !res_valid_o && $stable(res_o);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result changed or pulsed without a command");

  // Identification reads use the separate space, so never the bank
  property p_id_len;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && is_id |-> addr_len_o == 3'h4;
  endproperty
  a_id_len: assert property (p_id_len)
    else $error("identification read not given four address bytes");

endmodule // fae_addr_unit

/* File: rtl/fae_cfg.svh */
/*
  Constants of the flash address extension block: bank register layout,
  reset values, address widths, sector geometry and opcodes.
  Assumes it is included by bare name from design and bench files.
*/
`ifndef FAE_CFG_SVH
`define FAE_CFG_SVH

// ----------------------------------------------------------------------
// Bank register
// ----------------------------------------------------------------------
`define FAE_BANK_W        8
`define FAE_BANK_RST      8'h00
`define FAE_BANK_EXT_BIT  7
`define FAE_BANK_HI_MSB   6

// ----------------------------------------------------------------------
// Address formation
// ----------------------------------------------------------------------
`define FAE_FULL_AW       32
`define FAE_LEGACY_AW     24
`define FAE_LEN_LEGACY    3'h3
`define FAE_LEN_FULL      3'h4

// ----------------------------------------------------------------------
// Main array geometry: 256 uniform sectors of 512 kbytes
// ----------------------------------------------------------------------
`define FAE_SECT_LSB      19
`define FAE_SECT_W        8
`define FAE_SECT_LAST     8'hFF

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define FAE_OPC_READ_ID   8'h9F

`endif

/* File: rtl/fae_pkg.sv */
/*
  Types of the flash address extension block.
  Assumes fae_cfg.svh is on the include path.
*/
`include "fae_cfg.svh"

package fae_pkg;

  // Address space that a command reaches
  typedef enum logic [1:0] {
    FAE_SP_MAIN,
    FAE_SP_ID,
    FAE_SP_ALT
  } fae_space_type;

  // One decoded command as the front end hands it over
  typedef struct packed {
    logic [7:0]  opcode;
    logic        four_byte;
    logic        alt_space;
    logic        write;
    logic [31:0] addr;
  } fae_cmd_type;

  // Resolved address as handed to the array or space logic
  typedef struct packed {
    logic [31:0]   addr;
    fae_space_type space;
    logic [7:0]    sector;
    logic [18:0]   offset;
    logic          in_array;
    logic          refused;
    logic          write;
  } fae_res_type;

endpackage : fae_pkg

/* File: rtl/fae_sector_map.sv */
/*
  Splits a main array byte address into sector index and offset.
  Assumes a purely combinational use; the caller registers results.
*/
`timescale 1ns/1ps
`include "fae_cfg.svh"

module fae_sector_map #(
  parameter int ADDR_W   = `FAE_FULL_AW,
  parameter int SECT_LSB = `FAE_SECT_LSB,
  parameter int SECT_W   = `FAE_SECT_W
) (
  // Address in
  input  wire logic [ADDR_W-1:0]   addr_i,
  // Split address out
  output logic      [SECT_W-1:0]   sector_o,
  output logic      [SECT_LSB-1:0] offset_o,
  output logic                     in_array_o
);

  localparam int TOP = SECT_LSB + SECT_W;

  // Equal sectors, numbered upward with the address
  assign sector_o   = addr_i[TOP-1:SECT_LSB];
  assign offset_o   = addr_i[SECT_LSB-1:0];
  // Anything above the last sector is outside the array
  assign in_array_o = ~|addr_i[ADDR_W-1:TOP];

endmodule // fae_sector_map

/* File: testbench/fae_addr_unit_test.sv */
/*
  Self-checking bench of the address unit with random and corner
  commands. Assumes the host model file and the design are compiled.
*/
`timescale 1ns/1ps
`include "fae_cfg.svh"

module fae_addr_unit_test;
  import fae_pkg::*;

  logic             sys_clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic             bank_wr_i;
  logic [7:0]       bank_data_i;
  logic             cmd_valid_i;
  fae_cmd_type      cmd_i;
  logic [2:0]       addr_len_o;
  logic             res_valid_o;
  fae_res_type      res_o;
  logic             array_wr_en_o;
  logic [7:0]       bank_o;
  logic             ext_mode_o;
  logic [7:0]       bank_exp;
  int               error_cnt   = 0;
  int               check_count = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  fae_host_model i_fae_host_model (
    .sys_clk_i  (sys_clk_i),
    .bank_wr_o  (bank_wr_i),
    .bank_data_o(bank_data_i),
    .cmd_valid_o(cmd_valid_i),
    .cmd_o      (cmd_i)
  );

  fae_addr_unit i_fae_addr_unit (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .bank_wr_i    (bank_wr_i),
    .bank_data_i  (bank_data_i),
    .cmd_valid_i  (cmd_valid_i),
    .cmd_i        (cmd_i),
    .addr_len_o   (addr_len_o),
    .res_valid_o  (res_valid_o),
    .res_o        (res_o),
    .array_wr_en_o(array_wr_en_o),
    .bank_o       (bank_o),
    .ext_mode_o   (ext_mode_o)
  );

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic is_full(input logic [7:0] bk, fae_cmd_type c);
    return bk[7] | c.four_byte | c.alt_space | (c.opcode == `FAE_OPC_READ_ID);
  endfunction

  function automatic fae_res_type expect_res(input logic [7:0] bk,
                                             input fae_cmd_type c);
    fae_res_type r;
    r.addr     = is_full(bk, c) ? c.addr : {1'b0, bk[6:0], c.addr[23:0]};
    r.space    = (c.opcode == `FAE_OPC_READ_ID) ? FAE_SP_ID :
                 c.alt_space ? FAE_SP_ALT : FAE_SP_MAIN;
    r.sector   = r.addr[26:19];
    r.offset   = r.addr[18:0];
    r.in_array = (r.space == FAE_SP_MAIN) && (r.addr[31:27] == 5'h00);
    r.refused  = c.write && (c.opcode == `FAE_OPC_READ_ID);
    r.write    = c.write;
    return r;
  endfunction

  // One command: length while offered, result just after the edge that takes it
  task automatic run_cmd(input fae_cmd_type c);
    fae_res_type r;
    r = expect_res(bank_exp, c);
    i_fae_host_model.issue(c, is_full(bank_exp, c));
    #1;
    check(addr_len_o, is_full(bank_exp, c) ? 3'h4 : 3'h3);
    @(posedge sys_clk_i);
    #1;
    check(res_o, r);
    check({res_valid_o, array_wr_en_o}, {1'b1, r.write & !r.refused});
  endtask

  task automatic load_bank(input logic [7:0] b);
    i_fae_host_model.load(b);
    bank_exp = b;
    check({bank_o, ext_mode_o}, {b, b[7]});
  endtask

  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    bank_exp  = 8'h00;
    check({bank_o, ext_mode_o, res_valid_o}, 10'h000);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin : main
    fae_cmd_type c;
    void'($urandom(32'h4150));
    do_reset();
    run_cmd('{8'h03, 1'b0, 1'b0, 1'b0, 32'h12345678});
    load_bank(8'h05);
    run_cmd('{8'h03, 1'b0, 1'b0, 1'b1, 32'hFF123456});
    run_cmd('{8'h12, 1'b1, 1'b0, 1'b1, 32'h07FFFFFF});
    run_cmd('{8'h12, 1'b1, 1'b0, 1'b0, 32'h08000000});
    run_cmd('{8'h9F, 1'b0, 1'b1, 1'b1, 32'h00000010});
    run_cmd('{8'h02, 1'b0, 1'b1, 1'b1, 32'hABCDEF01});
    i_fae_host_model.idle();
    // The last result pulse ends only at the edge that sees no command
    @(posedge sys_clk_i);
    #1;
    check({res_valid_o, array_wr_en_o}, 2'b00);
    load_bank(8'h85);
    run_cmd('{8'h03, 1'b0, 1'b0, 1'b0, 32'hFFFFFFFF});
    for (int i = 0; i < 80; i++)
    begin
      if ($urandom_range(7) == 0)
        load_bank(8'($urandom));
      c.four_byte = 1'($urandom_range(1));
      c.alt_space = ($urandom_range(3) == 0);
      c.write     = 1'($urandom_range(1));
      c.opcode    = 8'($urandom);
      c.addr      = $urandom;
      c.opcode = ($urandom_range(3) == 0) ? `FAE_OPC_READ_ID : c.opcode;
      run_cmd(c);
    end
    i_fae_host_model.idle();
    do_reset();
    run_cmd('{8'h03, 1'b0, 1'b0, 1'b0, 32'h89ABCDEF});
    i_fae_host_model.idle();
    complete_run();
  end

  initial
  begin : watchdog
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule // fae_addr_unit_test

/* File: testbench/fae_host_model.sv */
/*
  Host flash controller model: hands commands and bank loads to the
  address unit. Assumes it is clocked by the unit's sys_clk_i and that
  the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps

module fae_host_model
  import fae_pkg::*;
(
  // Clock
  input  wire logic                 sys_clk_i,
  // Requests to the device
  output logic                      bank_wr_o,
  output logic [7:0]                bank_data_o,
  output logic                      cmd_valid_o,
  output fae_pkg::fae_cmd_type      cmd_o
);
  initial
  begin
    bank_wr_o   = 1'b0;
    bank_data_o = 8'h00;
    cmd_valid_o = 1'b0;
    cmd_o       = '0;
  end

  // ----------------------------------------------------------------------
  // Requests change at the falling edge only
  // ----------------------------------------------------------------------
  // A 3-byte host never shifts bits 31:24, so they carry junk here
  task automatic issue(input fae_cmd_type c, input logic full);
    fae_cmd_type w;
    w = c;
    if (!full)
      w.addr[31:24] = ~c.addr[31:24];
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    // Full 32-bit addresses always go out whole
    cmd_o       = w;
  endtask

  task automatic load(input logic [7:0] b);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    bank_wr_o   = 1'b1;
    bank_data_o = b;
    @(negedge sys_clk_i);
    bank_wr_o   = 1'b0;
    bank_data_o = ~b;
  endtask

  task automatic idle();
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    cmd_o       = ~cmd_o;
  endtask
endmodule // fae_host_model
